// ===== hw/ascp_pkg.sv
// Purpose: Shared constants and types for the serial command port
// Assumes: Eight-bit command word, shifted most significant bit first
// Notes: Register select codes follow the converter's register map
package ascp_pkg;
    // ************************************************************
    // Command word layout
    // ************************************************************
    localparam int CMD_W = 8;
    localparam int POS_GATE = 7;
    localparam int POS_DIR = 6;
    localparam int POS_SEL_HI = 5;
    localparam int POS_SEL_LO = 3;
    localparam int POS_CONT = 2;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [2:0] SEL_CMD_STATUS = 3'h0;
    localparam logic [2:0] SEL_MODE = 3'h1;
    localparam logic [2:0] SEL_CONFIG = 3'h2;
    localparam logic [2:0] SEL_DATA = 3'h3;
    localparam logic [2:0] SEL_IDENT = 3'h4;
    localparam logic [2:0] SEL_OUTCTL = 3'h5;
    localparam logic [7:0] REG_CMD_OFFSET = 8'h00;
    localparam logic [5:0] LEN_REG8 = 6'h08;
    localparam logic [5:0] LEN_REG24 = 6'h18;
    // ************************************************************
    // Counts
    // ************************************************************
    localparam int RESYNC_ONES = 40;
    localparam int CNT_W = 6;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic gate;
        logic dir_read;
        logic [2:0] sel;
        logic cont_read;
        logic [1:0] zero;
    } ascp_cmd_s;

    typedef struct packed {
        logic dir_read;
        logic [2:0] sel;
        logic [5:0] len;
    } ascp_xfer_s;
endpackage : ascp_pkg

// ===== hw/ascp_port.sv
// Purpose: Serial command port front end on the host serial clock
// Assumes: Host shifts on sclk rising edges; sclk may stop between words
// Notes: Link registers are sampled into clk after a synchronised step toggle
`timescale 1ns/1ps
`default_nettype none
module ascp_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic link_sclk,
    input wire logic din,
    input wire logic cs_n,
    output logic [7:0] cmd_word,
    output logic xfer_active,
    output logic xfer_read,
    output logic [2:0] xfer_sel,
    output logic [7:0] wr_data,
    output logic [5:0] wr_len,
    output logic part_reset
);
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_XFER} ascp_state_e;

    localparam int CNT_W_L = ascp_pkg::CNT_W;
    localparam logic [CNT_W_L-1:0] ONES_LAST = CNT_W_L'(ascp_pkg::RESYNC_ONES - 1);

    // ************************************************************
    // Link domain
    // ************************************************************
    ascp_state_e state_r;
    logic [2:0] bit_cnt_r;
    logic [5:0] xfer_cnt_r;
    logic [5:0] shift_r;
    ascp_pkg::ascp_cmd_s cmd_r;
    logic [7:0] data_r;
    logic [CNT_W_L-1:0] ones_r;
    logic reset_tgl_r;
    logic step_tgl_r;
    ascp_pkg::ascp_xfer_s xfer_r;

    logic taken;
    logic resync_hit;
    logic word_done;
    logic xfer_last;
    assign taken = !cs_n;
    assign resync_hit = taken && din && (ones_r == ONES_LAST);
    assign word_done = (state_r == ST_CMD) && (bit_cnt_r == 3'h6);
    assign xfer_last = (state_r == ST_XFER) && (xfer_cnt_r == 6'h01);

    // Data phase length follows the select code alone
    function automatic logic [5:0] reg_len(input logic [2:0] sel);
        unique case (sel)
            ascp_pkg::SEL_MODE, ascp_pkg::SEL_CONFIG, ascp_pkg::SEL_DATA: reg_len = ascp_pkg::LEN_REG24;
            default: reg_len = ascp_pkg::LEN_REG8;
        endcase
    endfunction : reg_len

    // Ones count in every state, so a lost host can always resync
    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            ones_r <= '0;
        end else if (!din || resync_hit) begin
            ones_r <= '0;
        end else if (taken) begin
            ones_r <= ones_r + CNT_W_L'(1);
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            reset_tgl_r <= 1'b0;
        end else if (resync_hit) begin
            reset_tgl_r <= ~reset_tgl_r;
        end
    end

    // One flip per accepted edge marks when link registers may move
    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            step_tgl_r <= 1'b0;
        end else if (taken) begin
            step_tgl_r <= ~step_tgl_r;
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else if (resync_hit) begin
            state_r <= ST_IDLE;
        end else if (taken) begin
            unique case (state_r)
                ST_IDLE: begin
                    // A leading one is not clocked in
                    if (!din) begin
                        state_r <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (word_done) begin
                        state_r <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (xfer_last) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_r <= '0;
        end else if (resync_hit || (taken && (state_r != ST_CMD))) begin
            bit_cnt_r <= '0;
        end else if (taken) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r <= '0;
        end else if (resync_hit) begin
            shift_r <= '0;
        end else if (taken && (state_r == ST_CMD)) begin
            shift_r <= {shift_r[4:0], din};
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= ascp_pkg::CMD_RESET;
            xfer_r <= '0;
        end else if (resync_hit) begin
            cmd_r <= ascp_pkg::CMD_RESET;
            xfer_r <= '0;
        end else if (taken && word_done) begin
            // The gate bit was the leading zero
            cmd_r <= {1'b0, shift_r, din};
            xfer_r.dir_read <= shift_r[5];
            xfer_r.sel <= shift_r[4:2];
            xfer_r.len <= reg_len(shift_r[4:2]);
        end
    end

    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            xfer_cnt_r <= '0;
        end else if (resync_hit) begin
            xfer_cnt_r <= '0;
        end else if (taken && word_done) begin
            xfer_cnt_r <= reg_len(shift_r[4:2]);
        end else if (taken && (state_r == ST_XFER)) begin
            xfer_cnt_r <= xfer_cnt_r - 6'h01;
        end
    end

    // Read data leaves through another path; only writes land here
    always_ff @(posedge link_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            data_r <= '0;
        end else if (resync_hit) begin
            data_r <= '0;
        end else if (taken && (state_r == ST_XFER) && !xfer_r.dir_read) begin
            data_r <= {data_r[6:0], din};
        end
    end

    // ************************************************************
    // Crossing to clk
    // ************************************************************
    // Link registers except ones_r move only on an accepted edge, which also flips
    // step_tgl_r. Once the flip is through the synchroniser the word has
    // been still for several clk cycles and is taken whole. Limitation:
    // the link clock must stay far slower than clk, as at 48 ns per bit.
    logic step_s;
    logic step_d_r;
    logic take;
    logic tgl_seen_r;

    ascp_sync #(.W(1)) u_step_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(step_tgl_r),
        .q(step_s)
    );

    assign take = step_s ^ step_d_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_d_r <= 1'b0;
        end else begin
            step_d_r <= step_s;
        end
    end

    // The command word goes to the core only; no read path shows it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_word <= ascp_pkg::CMD_RESET;
            wr_data <= '0;
            xfer_read <= 1'b0;
            xfer_sel <= '0;
            wr_len <= '0;
            xfer_active <= 1'b0;
        end else if (take) begin
            cmd_word <= cmd_r;
            wr_data <= data_r;
            xfer_read <= xfer_r.dir_read;
            xfer_sel <= xfer_r.sel;
            wr_len <= xfer_r.len;
            xfer_active <= (state_r == ST_XFER);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_seen_r <= 1'b0;
            part_reset <= 1'b0;
        end else begin
            if (take) begin
                tgl_seen_r <= reset_tgl_r;
            end
            part_reset <= take && (reset_tgl_r != tgl_seen_r);
        end
    end
endmodule : ascp_port
`default_nettype wire

// ===== hw/ascp_sync.sv
// Purpose: Carry a level from the link domain into the system clock
// Assumes: Input level changes slowly compared to clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ascp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end
endmodule : ascp_sync
`default_nettype wire

// ===== tb/ascp_host.sv
// Purpose: Host serial port model
// Assumes: 48 ns bit period
// Notes: Clock parks high between bits
`timescale 1ns/1ps
`default_nettype none
module ascp_host (
    output logic link_sclk,
    output logic din,
    output logic cs_n
);
    initial begin
        link_sclk = 1'b1;
        din = 1'b0;
        cs_n = 1'b1;
    end
    // Inverse after hold, so a stale bit never looks valid
    task put(input logic b);
        cs_n = 1'b0;
        link_sclk = 1'b0;
        din = b;
        #24 link_sclk = 1'b1;
        #24 din = ~b;
    endtask : put
    // Clock a bit with the port deselected
    task skip(input logic b);
        cs_n = 1'b1;
        link_sclk = 1'b0;
        din = b;
        #24 link_sclk = 1'b1;
        #24 din = ~b;
    endtask : skip
endmodule : ascp_host
`default_nettype wire

// ===== tb/ascp_monitor.sv
// Purpose: Concurrent checks on the command port outputs
// Assumes: Outputs settle a few clk after each sclk edge
// Notes: Steady checks wait four cycles to ride out sync skew
`timescale 1ns/1ps
`default_nettype none
module ascp_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] cmd_word,
    input wire logic xfer_active,
    input wire logic xfer_read,
    input wire logic [2:0] xfer_sel,
    input wire logic [5:0] wr_len,
    input wire logic part_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_on;
        xfer_active [*4];
    endsequence
    a_gate_stays_zero: assert property (cmd_word[7] == 1'b0) else $error("gate bit set");
    a_len_by_sel: assert property (s_on |-> wr_len == ((xfer_sel inside {3'h1, 3'h2, 3'h3}) ? 6'h18 : 6'h08))
        else $error("bad length");
    a_dir_from_cmd: assert property (s_on |-> xfer_read == cmd_word[6]) else $error("bad direction");
    a_sel_from_cmd: assert property (s_on |-> xfer_sel == cmd_word[5:3]) else $error("bad select");
    a_cmd_held: assert property (s_on |-> $stable(cmd_word)) else $error("word moved");
    a_pulse_single: assert property (part_reset |=> !part_reset) else $error("long pulse");
    a_resync_idle: assert property (part_reset |-> ##[0:8] (!xfer_active && cmd_word == 8'h00))
        else $error("no resync");
    a_idle_after_rst: assert property ($fell(sys_rst) |-> !xfer_active && cmd_word == 8'h00)
        else $error("not idle");
    c_read: cover property (xfer_active && xfer_read);
    c_write_cmd: cover property (xfer_active && !xfer_read && xfer_sel == 3'h0);
    c_resync: cover property (part_reset);
endmodule : ascp_monitor
bind ascp_port ascp_monitor ascp_monitor_i (.clk, .sys_rst, .cmd_word, .xfer_active, .xfer_read, .xfer_sel,
    .wr_len, .part_reset);
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the command port
// Assumes: Fixed settle of eight clk after the last bit
// Notes: Host model owns the serial pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    wire logic link_sclk, din, cs_n, xfer_active, xfer_read, part_reset;
    wire logic [7:0] cmd_word, wr_data;
    wire logic [2:0] xfer_sel;
    wire logic [5:0] wr_len;
    int err_total = 0;
    int n_checks = 0;
    int n_rst = 0;
    always #2.5 clk = ~clk;
    ascp_port ascp_port_i (.clk(clk), .sys_rst(sys_rst), .link_sclk(link_sclk), .din(din), .cs_n(cs_n),
        .cmd_word(cmd_word), .xfer_active(xfer_active), .xfer_read(xfer_read), .xfer_sel(xfer_sel),
        .wr_data(wr_data), .wr_len(wr_len), .part_reset(part_reset));
    ascp_host ascp_host_i (.link_sclk(link_sclk), .din(din), .cs_n(cs_n));
    always @(posedge clk) if (part_reset === 1'b1) n_rst <= n_rst + 1;
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) ascp_host_i.put(v[i]);
        repeat (8) @(negedge clk);
    endtask : send
    task t_prefix;
        repeat (3) ascp_host_i.put(1'b1);
        send(8'h08);
        chk("cmd", cmd_word, 8'h08);
        chk("act", 8'(xfer_active), 8'h01);
        send(8'h12);
        send(8'h34);
        send(8'hA5);
        chk("data", wr_data, 8'hA5);
        chk("idle", 8'(xfer_active), 8'h00);
        $display("t_prefix done");
    endtask : t_prefix
    task t_table;
        logic [7:0] c [6];
        int n;
        c = '{8'h00, 8'h40, 8'h50, 8'h5C, 8'h60, 8'h68};
        for (int k = 0; k < 6; k++) begin
            n = (c[k][5:3] inside {3'h1, 3'h2, 3'h3}) ? 24 : 8;
            send(c[k]);
            chk("read", 8'(xfer_read), 8'(c[k][6]));
            chk("sel", 8'(xfer_sel), 8'(c[k][5:3]));
            chk("len", 8'(wr_len), 8'(n));
            repeat (n / 8) send(8'h00);
        end
        $display("t_table done");
    endtask : t_table
    task t_deselect;
        logic [7:0] v;
        v = 8'h48;
        for (int i = 7; i >= 0; i--) ascp_host_i.skip(v[i]);
        repeat (8) @(negedge clk);
        chk("desel_cmd", cmd_word, 8'h68);
        chk("desel_act", 8'(xfer_active), 8'h00);
        send(8'h00);
        chk("cmd_sel0", cmd_word, 8'h00);
        chk("act_sel0", 8'(xfer_active), 8'h01);
        send(8'hC3);
        chk("wr_sel0", wr_data, 8'hC3);
        chk("idle_sel0", 8'(xfer_active), 8'h00);
        $display("t_deselect done");
    endtask : t_deselect
    task t_rst_mid;
        send(8'h50);
        chk("mid_act", 8'(xfer_active), 8'h01);
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk("mid_cmd", cmd_word, 8'h00);
        chk("mid_act0", 8'(xfer_active), 8'h00);
        send(8'h40);
        chk("mid_read", 8'(xfer_read), 8'h01);
        send(8'h00);
        chk("mid_idle", 8'(xfer_active), 8'h00);
        $display("t_rst_mid done");
    endtask : t_rst_mid
    task t_resync;
        send(8'h08);
        repeat (39) ascp_host_i.put(1'b1);
        repeat (8) @(negedge clk);
        chk("rst39", 8'(n_rst), 8'h00);
        ascp_host_i.put(1'b1);
        repeat (8) @(negedge clk);
        chk("rst40", 8'(n_rst), 8'h01);
        chk("cmd0", cmd_word, 8'h00);
        chk("wr0", wr_data, 8'h00);
        $display("t_resync done");
    endtask : t_resync
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        ascp_host_i.put(1'b1);
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        chk("rst_cmd", cmd_word, 8'h00);
        chk("rst_act", 8'(xfer_active), 8'h00);
        t_prefix;
        t_table;
        t_deselect;
        t_rst_mid;
        t_resync;
        end_sim;
    end
    initial begin
        #100000;
        err_total++;
        end_sim;
    end
endmodule : testbench
`default_nettype wire
